// [logic/mfio_pin_sync.sv]
// Two flip-flop synchroniser for a bus of pin inputs.
`timescale 1ns/10ps
module mfio_pin_sync
#(
   parameter int W = 8
)
(
   input  wire logic         clock,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1;

   initial
   begin
      if (W < 1)
      begin
         $error("mfio_pin_sync width must be positive.");
      end
   end

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         stage1  <= '0;
         syncOut <= '0;
      end
      else
      begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// [logic/mfio_ports.sv]
// Register file and pin steering for ports 3, 5, 6 and 7.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps
// What this block does
// - Port-3 latch reads: bits 6..5, 2..0 undefined
// - Port-3 driver bit: zero open-drain, one push-pull
// - Serial enables put clock/data onto port-1 pins
// - Driver register undefined bits; bit 0 written zero
// - Pin-state register returns synchronised levels of port-3 pins 1 and 0
// - Port 5 has eight individually directed pins
// - Reset clears port-5 latch, direction, LCD select
// - Port-5 LCD select overrides; else direction decides
// - Port-5 read: pin, zero, or latch
// - Input-mode reads return pin, not latch
// - Port 6 has four pins at bits 4..1
// - Reset clears port-6 latch, direction; input control ones
// - Port-6 direction and input control choose pin use
// - Port-6 read: zero, pin, or latch
// - Port 7 has seven individually directed pins
// - Reset clears port-7 latch, direction, LCD select
// - Port-7 LCD select overrides; else direction decides
// - Port-7 read: pin, zero, or latch
// - Reset sets port-3 latch ones, driver register zero
module mfio_ports
   import mfio_pkg::*;
#(
   parameter int P5_W = 8,
   parameter int P6_W = 4,
   parameter int P7_W = 7
)
(
   input  wire logic                          clock,
   input  wire logic                          reset_n,
   input  wire logic [mfio_pkg::ADDR_W-1:0]   regAddr,
   input  wire logic [mfio_pkg::DATA_W-1:0]   regWrData,
   input  wire logic                          regWrite,
   input  wire logic                          regRead,
   output logic      [mfio_pkg::DATA_W-1:0]   regRdData,
   input  wire logic [2:0]                    port3PinIn,
   output logic      [2:0]                    port3PinOut,
   output logic      [2:0]                    port3PinOe,
   input  wire logic [P5_W-1:0]               port5PinIn,
   output logic      [P5_W-1:0]               port5PinOut,
   output logic      [P5_W-1:0]               port5PinOe,
   output logic      [P5_W-1:0]               port5SegmentSelect,
   input  wire logic [P6_W-1:0]               port6PinIn,
   output logic      [P6_W-1:0]               port6PinOut,
   output logic      [P6_W-1:0]               port6PinOe,
   output logic      [P6_W-1:0]               port6DigitalIn,
   output logic      [P6_W-1:0]               port6AnalogSelect,
   input  wire logic [P7_W-1:0]               port7PinIn,
   output logic      [P7_W-1:0]               port7PinOut,
   output logic      [P7_W-1:0]               port7PinOe,
   output logic      [P7_W-1:0]               port7SegmentSelect,
   output logic                               serialClockOutEnable,
   output logic                               serialDataOutEnable
);
   import mfio_pkg::*;

   logic [7:0]      port3OutputLatch;
   logic [7:0]      port3DriverControl;
   logic [P5_W-1:0] port5OutputLatch;
   logic [P5_W-1:0] port5Direction;
   logic [P5_W-1:0] port5LcdSelect;
   logic [P6_W-1:0] port6OutputLatch;
   logic [P6_W-1:0] port6Direction;
   logic [P6_W-1:0] port6InputControl;
   logic [P7_W-1:0] port7OutputLatch;
   logic [P7_W-1:0] port7Direction;
   logic [P7_W-1:0] port7LcdSelect;
   logic [2:0]      port3Sync;
   logic [P5_W-1:0] port5Sync;
   logic [P6_W-1:0] port6Sync;
   logic [P7_W-1:0] port7Sync;
   logic [P5_W-1:0] port5ReadView;
   logic [P6_W-1:0] port6ReadView;
   logic [P7_W-1:0] port7ReadView;
   logic [7:0]      next_regRdData;

   initial
   begin
      if (P5_W < 1 || P5_W > DATA_W || P7_W < 1 || P7_W > DATA_W)
      begin
         $error("mfio_ports port 5 or 7 width out of range.");
      end
      if (P6_W < 1 || P6_W + P6_LSB > DATA_W || P6_W > $bits(RST_P6_INCTL))
      begin
         $error("mfio_ports port 6 width out of range.");
      end
   end

   // Port-3 pins in order: index 2 is the output-only pin, 1 and 0 the two driver-selectable pins.
   mfio_pin_sync #(.W(3 + P5_W + P6_W + P7_W)) u_sync
   (
      .clock   (clock),
      .reset_n (reset_n),
      .asyncIn ({port3PinIn, port5PinIn, port6PinIn, port7PinIn}),
      .syncOut ({port3Sync, port5Sync, port6Sync, port7Sync})
   );

   // Port-3 registers.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         port3OutputLatch   <= RST_P3_LATCH;
         port3DriverControl <= RST_P3_DRIVER;
      end
      else if (regWrite)
      begin
         if (regAddr == OFS_P3_LATCH)
         begin
            // Bits 2..0 are stored as written; software keeps them at one.
            port3OutputLatch <= regWrData;
         end
         if (regAddr == OFS_P3_DRIVER)
         begin
            port3DriverControl <= regWrData;
         end
      end
   end

   // Port-5 registers.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         port5OutputLatch <= P5_W'(RST_ZERO);
         port5Direction   <= P5_W'(RST_ZERO);
         port5LcdSelect   <= P5_W'(RST_ZERO);
      end
      else if (regWrite)
      begin
         if (regAddr == OFS_P5_LATCH)
         begin
            port5OutputLatch <= regWrData[P5_W-1:0];
         end
         if (regAddr == OFS_P5_DIR)
         begin
            port5Direction <= regWrData[P5_W-1:0];
         end
         if (regAddr == OFS_P5_LCD)
         begin
            port5LcdSelect <= regWrData[P5_W-1:0];
         end
      end
   end

   // Port-6 registers; the pins sit at bits 4..1 of each register.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         port6OutputLatch  <= P6_W'(RST_ZERO);
         port6Direction    <= P6_W'(RST_ZERO);
         port6InputControl <= P6_W'(RST_P6_INCTL);
      end
      else if (regWrite)
      begin
         if (regAddr == OFS_P6_LATCH)
         begin
            port6OutputLatch <= regWrData[P6_LSB +: P6_W];
         end
         if (regAddr == OFS_P6_DIR)
         begin
            // Unused positions have no storage, so stray ones there are harmless.
            port6Direction <= regWrData[P6_LSB +: P6_W];
         end
         if (regAddr == OFS_P6_INCTL)
         begin
            port6InputControl <= regWrData[P6_LSB +: P6_W];
         end
      end
   end

   // Port-7 registers.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         port7OutputLatch <= P7_W'(RST_ZERO);
         port7Direction   <= P7_W'(RST_ZERO);
         port7LcdSelect   <= P7_W'(RST_ZERO);
      end
      else if (regWrite)
      begin
         if (regAddr == OFS_P7_LATCH)
         begin
            port7OutputLatch <= regWrData[P7_W-1:0];
         end
         if (regAddr == OFS_P7_DIR)
         begin
            port7Direction <= regWrData[P7_W-1:0];
         end
         if (regAddr == OFS_P7_LCD)
         begin
            port7LcdSelect <= regWrData[P7_W-1:0];
         end
      end
   end

   // Port-3 pin drivers.
   always_comb
   begin
      port3PinOut    = '0;
      port3PinOe     = '0;
      port3PinOut[2] = port3OutputLatch[P3_BIT_HI];
      port3PinOe[2]  = 1'b1;
      // An open-drain pin only ever sinks, so it never fights an external pull-up.
      port3PinOut[1] = port3OutputLatch[P3_BIT_B];
      port3PinOe[1]  = port3DriverControl[P3_BIT_B] | ~port3OutputLatch[P3_BIT_B];
      port3PinOut[0] = port3OutputLatch[P3_BIT_A];
      port3PinOe[0]  = port3DriverControl[P3_BIT_A] | ~port3OutputLatch[P3_BIT_A];
   end

   assign serialDataOutEnable  = port3DriverControl[BIT_SDO_EN];
   assign serialClockOutEnable = port3DriverControl[BIT_SCK_EN];

   // Per-pin steering for ports 5, 6 and 7.
   genvar gi;
   generate
      for (gi = 0; gi < P5_W; gi++)
      begin : g_p5
         assign port5SegmentSelect[gi] = port5LcdSelect[gi];
         assign port5PinOe[gi]  = ~port5LcdSelect[gi] & port5Direction[gi];
         assign port5PinOut[gi] = port5OutputLatch[gi];
         assign port5ReadView[gi] = port5Direction[gi] ? port5OutputLatch[gi] :
                                    (port5LcdSelect[gi] ? 1'b0 : port5Sync[gi]);
      end
      for (gi = 0; gi < P6_W; gi++)
      begin : g_p6
         assign port6PinOe[gi]  = port6Direction[gi];
         assign port6PinOut[gi] = port6OutputLatch[gi];
         assign port6DigitalIn[gi] = ~port6Direction[gi] & port6InputControl[gi] &
                                     port6Sync[gi];
         assign port6AnalogSelect[gi] = ~port6Direction[gi] & ~port6InputControl[gi];
         assign port6ReadView[gi] = port6Direction[gi] ? port6OutputLatch[gi] :
                                    (port6InputControl[gi] ? port6Sync[gi] : 1'b0);
      end
      for (gi = 0; gi < P7_W; gi++)
      begin : g_p7
         assign port7SegmentSelect[gi] = port7LcdSelect[gi];
         assign port7PinOe[gi]  = ~port7LcdSelect[gi] & port7Direction[gi];
         assign port7PinOut[gi] = port7OutputLatch[gi];
         assign port7ReadView[gi] = port7Direction[gi] ? port7OutputLatch[gi] :
                                    (port7LcdSelect[gi] ? 1'b0 : port7Sync[gi]);
      end
   endgenerate

   // Read multiplexer; undefined bits return a fixed fill value.
   always_comb
   begin
      next_regRdData = '0;
      case (regAddr)
         OFS_P3_LATCH:
         begin
            next_regRdData = UNDEF_FILL;
            next_regRdData[P3_BIT_HI] = port3OutputLatch[P3_BIT_HI];
            next_regRdData[P3_BIT_B]  = port3OutputLatch[P3_BIT_B];
            next_regRdData[P3_BIT_A]  = port3OutputLatch[P3_BIT_A];
         end
         OFS_P3_PINS:
         begin
            next_regRdData = UNDEF_FILL;
            next_regRdData[P3_BIT_B] = port3Sync[1];
            next_regRdData[P3_BIT_A] = port3Sync[0];
         end
         OFS_P3_DRIVER:
         begin
            next_regRdData = UNDEF_FILL;
            next_regRdData[P3_BIT_B:BIT_SDO_EN] = port3DriverControl[P3_BIT_B:BIT_SDO_EN];
         end
         OFS_P5_LATCH:  next_regRdData[P5_W-1:0] = port5ReadView;
         OFS_P5_DIR:    next_regRdData[P5_W-1:0] = port5Direction;
         OFS_P5_LCD:    next_regRdData[P5_W-1:0] = port5LcdSelect;
         OFS_P6_LATCH:  next_regRdData[P6_LSB +: P6_W] = port6ReadView;
         OFS_P6_DIR:    next_regRdData[P6_LSB +: P6_W] = port6Direction;
         OFS_P6_INCTL:  next_regRdData[P6_LSB +: P6_W] = port6InputControl;
         OFS_P7_LATCH:  next_regRdData[P7_W-1:0] = port7ReadView;
         OFS_P7_DIR:    next_regRdData[P7_W-1:0] = port7Direction;
         OFS_P7_LCD:    next_regRdData[P7_W-1:0] = port7LcdSelect;
         default:       next_regRdData = '0;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         regRdData <= '0;
      end
      else if (regRead)
      begin
         regRdData <= next_regRdData;
      end
      else
      begin
         regRdData <= '0;
      end
   end

   a_p3_reset_value : assert property (@(posedge clock)
      $rose(reset_n) |-> port3OutputLatch == RST_P3_LATCH && port3DriverControl == RST_P3_DRIVER)
      else $error("Port-3 registers wrong after reset.");
   a_p3_open_drain : assert property (@(posedge clock) disable iff (!reset_n)
      (!port3DriverControl[P3_BIT_A] && port3OutputLatch[P3_BIT_A]) |-> !port3PinOe[0])
      else $error("Open-drain pin driven while released.");
   a_p3_push_pull : assert property (@(posedge clock) disable iff (!reset_n)
      port3DriverControl[P3_BIT_B] |-> port3PinOe[1] && port3PinOut[1] == port3OutputLatch[P3_BIT_B])
      else $error("Push-pull pin not driven.");
   a_serial_enable : assert property (@(posedge clock) disable iff (!reset_n)
      (regWrite && regAddr == OFS_P3_DRIVER) |=> serialClockOutEnable == $past(regWrData[BIT_SCK_EN]))
      else $error("Serial clock enable did not follow write.");
   a_p5_lcd_wins : assert property (@(posedge clock) disable iff (!reset_n)
      port5LcdSelect[0] |-> !port5PinOe[0] && port5SegmentSelect[0])
      else $error("Port-5 pin driven while segment.");
   a_p5_read_view : assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == OFS_P5_LATCH)
      |=> (regRdData[P5_W-1:0] & ~$past(port5Direction) & $past(port5LcdSelect)) == '0)
      else $error("Port-5 segment bit read not zero.");
   a_p6_read_zero : assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == OFS_P6_LATCH && !port6Direction[0] && !port6InputControl[0])
      |=> regRdData[P6_LSB] == 1'b0)
      else $error("Port-6 analog bit read not zero.");
   a_p6_reset_value : assert property (@(posedge clock)
      $rose(reset_n) |-> port6InputControl == RST_P6_INCTL && port6Direction == '0)
      else $error("Port-6 registers wrong after reset.");
   a_p7_latch_read : assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == OFS_P7_LATCH && port7Direction[0]) |=> regRdData[0] == $past(port7OutputLatch[0]))
      else $error("Port-7 output bit read not latch.");
   a_pin_state_read : assert property (@(posedge clock) disable iff (!reset_n)
      (regRead && regAddr == OFS_P3_PINS) |=> regRdData[P3_BIT_A] == $past(port3Sync[0]))
      else $error("Pin-state read wrong.");
   c_p5_output : cover property (@(posedge clock) |(port5PinOe & port5PinOut));
   c_p6_analog : cover property (@(posedge clock) port6AnalogSelect[0]);
   c_p3_sink : cover property (@(posedge clock) port3PinOe[0] && !port3PinOut[0]);
   c_serial_on : cover property (@(posedge clock) serialDataOutEnable && serialClockOutEnable);
endmodule

// [shared/mfio_pkg.sv]
// Package with register offsets, reset values and pin positions for the multi-function ports.
package mfio_pkg;
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 8;
   localparam logic [11:0] OFS_P3_LATCH   = 12'h003;
   localparam logic [11:0] OFS_P3_PINS    = 12'hf9d;
   localparam logic [11:0] OFS_P3_DRIVER  = 12'hf9e;
   localparam logic [11:0] OFS_P5_LATCH   = 12'h005;
   localparam logic [11:0] OFS_P5_DIR     = 12'hf50;
   localparam logic [11:0] OFS_P5_LCD     = 12'hf51;
   localparam logic [11:0] OFS_P6_LATCH   = 12'h006;
   localparam logic [11:0] OFS_P6_DIR     = 12'hf60;
   localparam logic [11:0] OFS_P6_INCTL   = 12'hf61;
   localparam logic [11:0] OFS_P7_LATCH   = 12'h007;
   localparam logic [11:0] OFS_P7_DIR     = 12'hf70;
   localparam logic [11:0] OFS_P7_LCD     = 12'hf71;
   localparam logic [7:0]  RST_P3_LATCH   = 8'hff;
   localparam logic [7:0]  RST_P3_DRIVER  = 8'h00;
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [3:0]  RST_P6_INCTL   = 4'hf;
   localparam logic [7:0]  UNDEF_FILL     = 8'h00;
   localparam int          P3_BIT_HI      = 7;
   localparam int          P3_BIT_B      = 4;
   localparam int          P3_BIT_A      = 3;
   localparam int          BIT_SDO_EN     = 1;
   localparam int          BIT_SCK_EN     = 2;
   localparam int          P6_LSB         = 1;
endpackage

// [tb/mfio_pin_model.sv]
// Pin-side model: resolves each port pin from the block's driver and an external level.
`timescale 1ns/10ps
module mfio_pin_model
#(
   parameter int W = 8
)
(
   input  wire logic [W-1:0] pinOut,
   input  wire logic [W-1:0] pinOe,
   input  wire logic [W-1:0] extLevel,
   output logic      [W-1:0] pinLevel
);
   // A released pin shows whatever the outside world holds it at, pull-up or driver.
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         pinLevel[i] = pinOe[i] ? pinOut[i] : extLevel[i];
      end
   end
endmodule

// [tb/multi_function_io_ports_tb_top.sv]
// Self-checking bench for the multi-function port registers and pin steering.
`timescale 1ns/10ps
module multi_function_io_ports_tb_top;
   import mfio_pkg::*;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic [11:0] regAddr = 12'h000;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [7:0]  regRdData, rd;
   logic [2:0]  p3In, p3Out, p3Oe;
   logic [2:0]  p3Ext = 3'h7;
   logic [7:0]  p5In, p5Out, p5Oe, p5Seg;
   logic [7:0]  p5Ext = 8'h1e;
   logic [3:0]  p6In, p6Out, p6Oe, p6Dig, p6Ana;
   logic [3:0]  p6Ext = 4'ha;
   logic [6:0]  p7In, p7Out, p7Oe, p7Seg;
   logic [6:0]  p7Ext = 7'h2d;
   logic        sck, sdo;
   int          nFail = 0;
   int          testsRun = 0;

   always #20 clock = ~clock;

   mfio_ports u_mfio_ports
   (
      .clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .port3PinIn(p3In), .port3PinOut(p3Out), .port3PinOe(p3Oe),
      .port5PinIn(p5In), .port5PinOut(p5Out), .port5PinOe(p5Oe), .port5SegmentSelect(p5Seg),
      .port6PinIn(p6In), .port6PinOut(p6Out), .port6PinOe(p6Oe), .port6DigitalIn(p6Dig),
      .port6AnalogSelect(p6Ana), .port7PinIn(p7In), .port7PinOut(p7Out), .port7PinOe(p7Oe),
      .port7SegmentSelect(p7Seg), .serialClockOutEnable(sck), .serialDataOutEnable(sdo)
   );
   mfio_pin_model #(.W(3)) u3 (.pinOut(p3Out), .pinOe(p3Oe), .extLevel(p3Ext), .pinLevel(p3In));
   mfio_pin_model #(.W(8)) u5 (.pinOut(p5Out), .pinOe(p5Oe), .extLevel(p5Ext), .pinLevel(p5In));
   mfio_pin_model #(.W(4)) u6 (.pinOut(p6Out), .pinOe(p6Oe), .extLevel(p6Ext), .pinLevel(p6In));
   mfio_pin_model #(.W(7)) u7 (.pinOut(p7Out), .pinOe(p7Oe), .extLevel(p7Ext), .pinLevel(p7In));

   task automatic summarize();
      $display("Checks run %0d, mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic checkVal(input string name, input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp)
      begin
         nFail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic regWr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask

   task automatic regRd(input logic [11:0] a, output logic [7:0] d);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask

   task automatic readExpect(input string name, input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      regRd(a, d);
      checkVal(name, exp, d);
   endtask

   // Pin inputs pass a two-stage synchroniser, so let them land before reading.
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask

   initial
   begin
      repeat (4000) @(posedge clock);
      nFail++;
      summarize();
   end

   initial
   begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      settle();
      readExpect("p3 latch", OFS_P3_LATCH, RST_P3_LATCH & 8'h98);
      readExpect("p3 driver", OFS_P3_DRIVER, RST_P3_DRIVER);
      checkVal("p3 oe", 8'h04, 8'(p3Oe));
      readExpect("p3 pins", OFS_P3_PINS, 8'h18);
      p3Ext <= 3'b100;
      settle();
      readExpect("p3 pins low", OFS_P3_PINS, 8'h00);
      p3Ext <= 3'b111;
      regWr(OFS_P3_LATCH, 8'h67);
      checkVal("p3 oe sink", 8'h07, 8'(p3Oe));
      checkVal("p3 out sink", 8'h00, 8'(p3Out));
      readExpect("p3 latch rd", OFS_P3_LATCH, 8'h00);
      regWr(OFS_P3_DRIVER, 8'h18);
      regWr(OFS_P3_LATCH, 8'h9f);
      p3Ext <= 3'b100;
      checkVal("p3 oe pp", 8'h07, 8'(p3Oe));
      settle();
      readExpect("p3 pins pp", OFS_P3_PINS, 8'h18);
      regWr(OFS_P3_DRIVER, 8'h08);
      checkVal("p3 oe od", 8'h05, 8'(p3Oe));
      settle();
      readExpect("p3 pins od", OFS_P3_PINS, 8'h08);
      for (int k = 0; k < 4; k++)
      begin
         regWr(OFS_P3_DRIVER, 8'(k * 2));
         checkVal("sck en", 8'(k / 2), 8'(sck));
         checkVal("sdo en", 8'(k % 2), 8'(sdo));
      end
      regWr(OFS_P3_DRIVER, 8'hfe);
      readExpect("p3 driver rd", OFS_P3_DRIVER, 8'h1e);
      readExpect("p5 dir", OFS_P5_DIR, RST_ZERO);
      readExpect("p5 lcd", OFS_P5_LCD, RST_ZERO);
      readExpect("p5 in", OFS_P5_LATCH, p5Ext);
      readExpect("p7 dir", OFS_P7_DIR, RST_ZERO);
      readExpect("p7 lcd", OFS_P7_LCD, RST_ZERO);
      readExpect("p7 in", OFS_P7_LATCH, 8'(p7Ext));
      readExpect("p6 dir", OFS_P6_DIR, RST_ZERO);
      readExpect("p6 ictl", OFS_P6_INCTL, {3'h0, RST_P6_INCTL, 1'b0});
      readExpect("p6 in", OFS_P6_LATCH, {3'h0, p6Ext, 1'b0});
      checkVal("p6 dig", 8'(p6Ext), 8'(p6Dig));
      checkVal("p6 ana", 8'h00, 8'(p6Ana));
      regWr(OFS_P5_DIR, 8'h33);
      regWr(OFS_P5_LCD, 8'h55);
      regWr(OFS_P5_LATCH, 8'ha5);
      checkVal("p5 oe", 8'h22, p5Oe);
      checkVal("p5 seg", 8'h55, p5Seg);
      checkVal("p5 out", 8'ha5, p5Out);
      regRd(OFS_P5_LATCH, rd);
      checkVal("p5 rd", (8'h33 & 8'ha5) | (8'hcc & 8'haa & p5Ext), rd);
      regWr(OFS_P5_LATCH, rd);
      regWr(OFS_P5_DIR, 8'hff);
      readExpect("p5 wb", OFS_P5_LATCH, rd);
      regWr(OFS_P7_DIR, 8'h33);
      regWr(OFS_P7_LCD, 8'h55);
      regWr(OFS_P7_LATCH, 8'ha5);
      checkVal("p7 oe", 8'h22, 8'(p7Oe));
      checkVal("p7 seg", 8'h55, 8'(p7Seg));
      checkVal("p7 out", 8'h25, 8'(p7Out));
      readExpect("p7 rd", OFS_P7_LATCH, 8'h21 | (8'h88 & 8'(p7Ext)));
      regWr(OFS_P6_DIR, 8'h0c);
      regWr(OFS_P6_INCTL, 8'h14);
      regWr(OFS_P6_LATCH, 8'hff);
      checkVal("p6 oe", 8'h06, 8'(p6Oe));
      checkVal("p6 out", 8'h0f, 8'(p6Out));
      checkVal("p6 ana", 8'h01, 8'(p6Ana));
      checkVal("p6 dig", 8'(4'h8 & p6Ext), 8'(p6Dig));
      readExpect("p6 rd", OFS_P6_LATCH, {3'h0, 4'h6 | (4'h8 & p6Ext), 1'b0});
      // A second reset after every register has been moved off its reset value.
      regWr(OFS_P3_LATCH, 8'h07);
      @(posedge clock);
      reset_n <= 1'b0;
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      settle();
      readExpect("p3 latch rst", OFS_P3_LATCH, RST_P3_LATCH & 8'h98);
      readExpect("p3 driver rst", OFS_P3_DRIVER, RST_P3_DRIVER);
      checkVal("sck en rst", 8'h00, 8'(sck));
      readExpect("p5 dir rst", OFS_P5_DIR, RST_ZERO);
      checkVal("p5 out rst", RST_ZERO, p5Out);
      readExpect("p7 lcd rst", OFS_P7_LCD, RST_ZERO);
      checkVal("p7 out rst", RST_ZERO, 8'(p7Out));
      readExpect("p6 ictl rst", OFS_P6_INCTL, {3'h0, RST_P6_INCTL, 1'b0});
      checkVal("p6 out rst", RST_ZERO, 8'(p6Out));
      checkVal("p6 oe rst", RST_ZERO, 8'(p6Oe));
      regWr(12'h123, 8'hff);
      readExpect("unmapped", 12'h123, 8'h00);
      @(posedge clock);
      #1;
      checkVal("rd idle", 8'h00, regRdData);
      summarize();
   end
endmodule
